// [core/adcs_sequencer.sv]
// Behaviour
// RULE_01: control register 0 holds clock select in 7-6, channel in 5-3, go in 2, power in 0, bit 1 reads zero.
// RULE_02: on completion the result register loads, go clears and the done flag sets.
// RULE_03: a three-bit port configuration field in control register 1 picks analog or digital pins and reference; the code decodes only the analog pin mask.
// RULE_04: a full conversion lasts nine and a half bit periods.
// RULE_05: clock select 00, 01, 10 give 2, 8, 32 clocks per bit period and 11 uses the RC source.
// RULE_06: software picks a setting whose bit period is at least 1.6 us.
// RULE_07: after a conversion, two bit periods pass with the hold capacitor disconnected before acquiring.
// RULE_08: clearing go during a conversion aborts it at once.
// RULE_09: an aborted conversion leaves the result register untouched.
// RULE_10: after an abort, two bit periods pass and then acquisition restarts on the selected channel.
// RULE_11: software does not set go in the same write that powers the converter on.
// RULE_12: software lets the acquisition time elapse before setting go.
// RULE_13: a port read returns zero for every pin configured as analog.
// RULE_14: an analog pin set as output is converted from its own driven level.
// RULE_15: completion sets the done flag and clears go so software may poll or take the interrupt.
// RULE_16: go reads set for the whole conversion and clears only on completion or abort.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

`include "adcs_regs.svh"

module adcs_sequencer
    import adcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic rc_osc,
    input wire logic [63:0] ain,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic sample_connect
);

    adcs_state_t cur;
    adcs_state_t next_cur;
    adcs_bus_req_t req;

    // channel n sits on pin n
    function automatic logic [7:0] adcs_analog_mask(input logic [2:0] pcfg);
        logic [7:0] m;
        m = `ADCS_RST_BYTE;
        case (pcfg)
            3'h0: m = 8'hff;
            3'h1: m = 8'hf7;
            3'h2: m = 8'h1f;
            3'h3: m = 8'h17;
            3'h4: m = 8'h0b;
            3'h5: m = 8'h03;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    function automatic logic [4:0] adcs_half_limit(input logic [1:0] sel);
        logic [4:0] h;
        h = `ADCS_HALF_DIV2;
        case (sel)
            `ADCS_CS_DIV2: h = `ADCS_HALF_DIV2;
            `ADCS_CS_DIV8: h = `ADCS_HALF_DIV8;
            `ADCS_CS_DIV32: h = `ADCS_HALF_DIV32;
            default: h = `ADCS_HALF_DIV2;
        endcase
        return h;
    endfunction

    logic [7:0] an_mask;
    logic [7:0] chan_level [0:7];
    logic [7:0] pin_read;

    assign an_mask = adcs_analog_mask(cur.pcfg);
    assign req.addr = addr;
    assign req.wdata = wdata;
    assign req.wr = wr;
    assign req.rd = rd;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_chan
            // output-driven pin converts its own digital level
            assign chan_level[gi] = cur.dir[gi] ? ain[gi*8 +: 8]
                : {8{cur.port_latch[gi]}}; // RULE_14
            assign pin_read[gi] = an_mask[gi] ? 1'b0 : cur.pin_s2[gi]; // RULE_13
        end
    endgenerate

    always_comb
    begin
        logic half_tick;
        logic wr_ctrl0;
        logic go_wr;
        logic done_ev;
        logic abort_ev;
        logic [1:0] clr;
        half_tick = 1'b0;
        wr_ctrl0 = req.wr && (req.addr == `ADCS_OFS_CTRL0);
        go_wr = req.wdata[`ADCS_GO_BIT];
        done_ev = 1'b0;
        abort_ev = 1'b0;
        clr = 2'h0;
        next_cur = cur;

        next_cur.rc_s1 = rc_osc;
        next_cur.rc_s2 = cur.rc_s1;
        next_cur.rc_s3 = cur.rc_s2;
        next_cur.pin_s1 = pin_in;
        next_cur.pin_s2 = cur.pin_s1;

        // half bit period: rc edges, or a divided ref_clk
        if (cur.clk_sel == `ADCS_CS_RC) // RULE_05
        begin
            half_tick = cur.rc_s2 ^ cur.rc_s3;
            next_cur.div_cnt = `ADCS_RST_CNT;
        end
        else if (cur.div_cnt >= adcs_half_limit(cur.clk_sel)) // RULE_05
        begin
            half_tick = 1'b1;
            next_cur.div_cnt = `ADCS_RST_CNT;
        end
        else
        begin
            next_cur.div_cnt = cur.div_cnt + 5'h01;
        end

        case (cur.phase)
            ADCS_ACQUIRE:
            begin
                // go only starts a converter that was already on
                if (wr_ctrl0 && go_wr && cur.pwr) // RULE_11
                begin
                    next_cur.phase = ADCS_CONVERT;
                    next_cur.hold = chan_level[cur.chan];
                    next_cur.half_cnt = `ADCS_RST_CNT;
                    next_cur.div_cnt = `ADCS_RST_CNT;
                end
            end
            ADCS_CONVERT:
            begin
                // power-off also kills the conversion
                if ((wr_ctrl0 && !go_wr) || (wr_ctrl0 && !req.wdata[`ADCS_PWR_BIT]))
                begin
                    abort_ev = 1'b1; // RULE_08
                    next_cur.phase = ADCS_RECOVER; // RULE_10
                    next_cur.half_cnt = `ADCS_RST_CNT;
                    next_cur.div_cnt = `ADCS_RST_CNT;
                end
                else if (half_tick)
                begin
                    if (cur.half_cnt == `ADCS_CONV_HALVES - 5'h01) // RULE_04
                    begin
                        done_ev = 1'b1; // RULE_15
                        next_cur.phase = ADCS_RECOVER; // RULE_07
                        next_cur.half_cnt = `ADCS_RST_CNT;
                    end
                    else
                    begin
                        next_cur.half_cnt = cur.half_cnt + 5'h01;
                    end
                end
            end
            ADCS_RECOVER:
            begin
                if (half_tick)
                begin
                    if (cur.half_cnt == `ADCS_RECOV_HALVES - 5'h01) // RULE_07
                    begin
                        next_cur.phase = ADCS_ACQUIRE; // RULE_10
                        next_cur.half_cnt = `ADCS_RST_CNT;
                    end
                    else
                    begin
                        next_cur.half_cnt = cur.half_cnt + 5'h01;
                    end
                end
            end
            default:
            begin
                next_cur.phase = ADCS_ACQUIRE;
            end
        endcase

        // register writes; go itself lives in the phase
        if (req.wr)
        begin
            case (req.addr)
                `ADCS_OFS_CTRL0:
                begin
                    next_cur.clk_sel = req.wdata[`ADCS_CS_MSB:`ADCS_CS_LSB]; // RULE_01
                    next_cur.chan = req.wdata[`ADCS_CH_MSB:`ADCS_CH_LSB]; // RULE_01
                    next_cur.pwr = req.wdata[`ADCS_PWR_BIT]; // RULE_01
                end
                `ADCS_OFS_CTRL1: next_cur.pcfg = req.wdata[`ADCS_PCFG_MSB:`ADCS_PCFG_LSB]; // RULE_03
                `ADCS_OFS_RESULT: next_cur.result = req.wdata;
                `ADCS_OFS_CLEAR: clr = req.wdata[1:0];
                `ADCS_OFS_ENABLE: next_cur.irq_en = req.wdata[1:0];
                `ADCS_OFS_PORT: next_cur.port_latch = req.wdata;
                `ADCS_OFS_DIR: next_cur.dir = req.wdata;
                default: next_cur.pwr = next_cur.pwr;
            endcase
        end

        // completion beats a same-cycle software write of the result
        if (done_ev)
        begin
            next_cur.result = cur.hold; // RULE_02
        end
        // abort leaves result alone, RULE_09

        // set wins over clear
        next_cur.status[`ADCS_ST_DONE] = done_ev
            || (cur.status[`ADCS_ST_DONE] && !clr[`ADCS_ST_DONE]); // RULE_02
        next_cur.status[`ADCS_ST_ABORT] = abort_ev
            || (cur.status[`ADCS_ST_ABORT] && !clr[`ADCS_ST_ABORT]);
        next_cur.irq = |(next_cur.status & next_cur.irq_en);

        next_cur.rdata = `ADCS_RST_BYTE;
        if (req.rd)
        begin
            case (req.addr)
                `ADCS_OFS_CTRL0:
                begin
                    next_cur.rdata[`ADCS_CS_MSB:`ADCS_CS_LSB] = cur.clk_sel;
                    next_cur.rdata[`ADCS_CH_MSB:`ADCS_CH_LSB] = cur.chan;
                    next_cur.rdata[`ADCS_GO_BIT] = (cur.phase == ADCS_CONVERT); // RULE_16
                    next_cur.rdata[`ADCS_PWR_BIT] = cur.pwr;
                end
                `ADCS_OFS_CTRL1: next_cur.rdata[`ADCS_PCFG_MSB:`ADCS_PCFG_LSB] = cur.pcfg;
                `ADCS_OFS_RESULT: next_cur.rdata = cur.result;
                `ADCS_OFS_STATUS: next_cur.rdata[1:0] = cur.status;
                `ADCS_OFS_ENABLE: next_cur.rdata[1:0] = cur.irq_en;
                `ADCS_OFS_PORT: next_cur.rdata = pin_read; // RULE_13
                `ADCS_OFS_DIR: next_cur.rdata = cur.dir;
                default: next_cur.rdata = `ADCS_RST_BYTE;
            endcase
        end

        next_cur.pin_out = next_cur.port_latch;
        next_cur.pin_oe = ~next_cur.dir;
        // switch open while converting and recovering
        next_cur.sample_connect = next_cur.pwr && (next_cur.phase == ADCS_ACQUIRE); // RULE_07
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cur <= '0;
            cur.phase <= ADCS_ACQUIRE;
            cur.dir <= `ADCS_RST_DIR;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rdata = cur.rdata;
    assign irq = cur.irq;
    assign pin_out = cur.pin_out;
    assign pin_oe = cur.pin_oe;
    assign sample_connect = cur.sample_connect;

endmodule

// [core/adcs_regs.svh]
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// register offsets on the command port
`define ADCS_OFS_CTRL0 4'h0
`define ADCS_OFS_CTRL1 4'h1
`define ADCS_OFS_RESULT 4'h2
`define ADCS_OFS_STATUS 4'h3
`define ADCS_OFS_CLEAR 4'h4
`define ADCS_OFS_ENABLE 4'h5
`define ADCS_OFS_PORT 4'h6
`define ADCS_OFS_DIR 4'h7

// first control register fields
`define ADCS_CS_MSB 7
`define ADCS_CS_LSB 6
`define ADCS_CH_MSB 5
`define ADCS_CH_LSB 3
`define ADCS_GO_BIT 2
`define ADCS_PWR_BIT 0

// second control register field
`define ADCS_PCFG_MSB 2
`define ADCS_PCFG_LSB 0

// interrupt status bits
`define ADCS_ST_DONE 0
`define ADCS_ST_ABORT 1

// conversion clock select codes
`define ADCS_CS_DIV2 2'h0
`define ADCS_CS_DIV8 2'h1
`define ADCS_CS_DIV32 2'h2
`define ADCS_CS_RC 2'h3

// half bit period in ref_clk cycles, minus one
`define ADCS_HALF_DIV2 5'h00
`define ADCS_HALF_DIV8 5'h03
`define ADCS_HALF_DIV32 5'h0f

// conversion is 9.5 bit periods, recovery 2, counted in half periods
`define ADCS_CONV_HALVES 5'h13
`define ADCS_RECOV_HALVES 5'h04

// reset values
`define ADCS_RST_BYTE 8'h00
`define ADCS_RST_DIR 8'hff
`define ADCS_RST_CNT 5'h00

`endif

// [core/adcs_pkg.sv]
package adcs_pkg;

    typedef enum logic [1:0] {
        ADCS_ACQUIRE = 2'h0,
        ADCS_CONVERT = 2'h1,
        ADCS_RECOVER = 2'h3
    } adcs_phase_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcs_bus_req_t;

    typedef struct packed {
        adcs_phase_t phase;
        logic [1:0] clk_sel;
        logic [2:0] chan;
        logic pwr;
        logic [2:0] pcfg;
        logic [7:0] result;
        logic [7:0] port_latch;
        logic [7:0] dir;
        logic [1:0] status;
        logic [1:0] irq_en;
        logic [7:0] hold;
        logic [4:0] div_cnt;
        logic [4:0] half_cnt;
        logic [7:0] rdata;
        logic irq;
        logic rc_s1;
        logic rc_s2;
        logic rc_s3;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic sample_connect;
    } adcs_state_t;

endpackage

// [tb/adcs_sequencer_props.sv]
`timescale 1ns/100ps
module adcs_sequencer_props (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic sample_connect
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // start of a div2 conversion from an idle, powered converter
    sequence conv_start;
        wr && addr == 4'h0 && wdata[7:6] == 2'h0 && wdata[2] && wdata[0] && sample_connect;
    endsequence
    sequence conv_hold;
        (!sample_connect)[*8];
    endsequence
    // 19 half periods of conversion plus 4 of recovery, one clock each
    chk_conv_span: assert property (conv_start |=> conv_hold ##1 conv_hold ##1 (!sample_connect)[*7] ##1 sample_connect)
        else $error("conversion plus recovery span wrong");
    chk_reset_quiet: assert property ($fell(srst) |-> !irq && !sample_connect && rdata == 8'h00 && pin_oe == 8'h00)
        else $error("outputs not quiet after reset");
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    chk_ctrl0_gap: assert property (rd && addr == 4'h0 |=> rdata[1] == 1'b0)
        else $error("unused control bit reads set");
    chk_ctrl1_upper: assert property (rd && addr == 4'h1 |=> rdata[7:3] == 5'h00)
        else $error("port config upper bits set");
    chk_dir_drive: assert property (wr && addr == 4'h7 |=> pin_oe == ~$past(wdata))
        else $error("pin drive enable does not follow direction");
    chk_latch_out: assert property (wr && addr == 4'h6 |=> pin_out == $past(wdata))
        else $error("output latch not updated");
    chk_irq_mask: assert property (wr && addr == 4'h5 && wdata[1:0] == 2'h0 |-> ##[1:2] !irq)
        else $error("interrupt stays up when masked");
    chk_power_off: assert property (wr && addr == 4'h0 && !wdata[0] |-> ##[1:2] !sample_connect)
        else $error("hold capacitor connected after power off");
endmodule

bind adcs_sequencer adcs_sequencer_props adcs_sequencer_props_i (.ref_clk(ref_clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pin_out(pin_out), .pin_oe(pin_oe),
    .sample_connect(sample_connect));

// [tb/tb_adcs_sequencer.sv]
`timescale 1ns/100ps
module tb_adcs_sequencer;
    logic ref_clk = 0, srst = 1, wr = 0, rd = 0, rc_osc = 0, rd_q = 0, irq, sample_connect;
    logic [3:0] addr = 4'h0;
    logic [1:0] rc_div = 2'h0;
    logic [7:0] wdata = 8'h00, pin_in = 8'h00, rdata, pin_out, pin_oe, d, ex;
    logic [63:0] ain = 64'h0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'heb08;
    logic [7:0] masks [8] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00, 8'h00};
    logic [2:0] ch;
    int fail_count = 0, tests_run = 0, n;
    adcs_sequencer adcs_sequencer_i (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .rc_osc(rc_osc), .ain(ain), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .sample_connect(sample_connect));
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        rc_div <= rc_div + 2'h1;
        if (rc_div == 2'h3)
            rc_osc <= ~rc_osc;
    end
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(logic [15:0] got, logic [15:0] want);
        tests_run++;
        if (got !== want)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, want);
        end
    endtask
    // for reads v carries the expected value
    task automatic bus(logic w, logic r, logic [3:0] a, logic [7:0] v);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= v;
        if (r)
            exp_q.push_back(v);
        @(posedge ref_clk);
    endtask
    task automatic wait_for(bit want_irq, output int c);
        c = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            c++;
        end while (!(want_irq ? irq : sample_connect) && c < 2000);
    endtask
    task conclude;
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        if (rd_q)
            check(rdata, exp_q.pop_front());
        rd_q <= rd;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        conclude();
    end
    initial
    begin
        repeat (10) @(posedge ref_clk);
        srst <= 0;
        pin_in <= xs();
        foreach (masks[i])
            bus(0, 1, (i < 4) ? i : (i == 7 ? 4'h7 : 4'hf), (i == 7) ? 8'hff : 8'h00);
        d = xs();
        bus(1, 0, 4'h0, d & 8'hfb);
        bus(0, 1, 4'h0, d & 8'hf9);
        bus(1, 0, 4'h1, d);
        bus(0, 1, 4'h1, d & 8'h07);
        for (int p = 0; p < 8; p++)
        begin
            bus(1, 0, 4'h1, p);
            bus(0, 1, 4'h6, pin_in & ~masks[p]);
        end
        bus(1, 0, 4'h1, 8'h00);
        bus(1, 0, 4'h5, 8'h03);
        bus(1, 0, 4'h6, 8'h04);
        ain <= {xs(), xs()};
        for (int cs = 0; cs < 4; cs++)
        begin
            ch = (cs == 0) ? 3'h2 : xs();
            // channel 2 driven as output converts its own latch level
            ex = (cs == 0) ? 8'hff : ain[ch * 8 +: 8];
            bus(1, 0, 4'h7, (cs == 0) ? 8'hfb : 8'hff);
            bus(1, 0, 4'h0, {cs[1:0], ch, 3'b001});
            repeat (8) @(posedge ref_clk);
            bus(1, 0, 4'h0, {cs[1:0], ch, 3'b101});
            bus(0, 1, 4'h0, {cs[1:0], ch, 3'b101});
            bus(0, 0, 4'h0, 8'h00);
            wait_for(1, n);
            if (cs != 3)
                // 19 half periods from the go edge, less the read and idle slots before counting
                check(n, 19 * (1 << (2 * cs)) - 2);
            bus(0, 1, 4'h2, ex);
            bus(0, 1, 4'h0, {cs[1:0], ch, 3'b001});
            bus(0, 1, 4'h3, 8'h01);
            bus(1, 0, 4'h5, 8'h00);
            bus(1, 0, 4'h4, 8'h03);
            bus(0, 1, 4'h3, 8'h00);
            bus(1, 0, 4'h5, 8'h03);
            bus(0, 0, 4'h0, 8'h00);
            wait_for(0, n);
        end
        bus(1, 0, 4'h2, 8'h5a);
        bus(1, 0, 4'h0, 8'h49);
        repeat (8) @(posedge ref_clk);
        bus(1, 0, 4'h0, 8'h4d);
        repeat (20) @(posedge ref_clk);
        bus(1, 0, 4'h0, 8'h49);
        bus(0, 0, 4'h0, 8'h00);
        wait_for(0, n);
        check(n, 15);
        bus(0, 1, 4'h2, 8'h5a);
        bus(0, 1, 4'h0, 8'h49);
        bus(0, 1, 4'h3, 8'h02);
        bus(1, 0, 4'h0, 8'h00);
        bus(1, 0, 4'h0, 8'h05);
        bus(0, 1, 4'h0, 8'h01);
        bus(0, 0, 4'h0, 8'h00);
        repeat (4) @(posedge ref_clk);
        conclude();
    end
endmodule
